// [hw/cfs_pkg.sv]
// Constants, pin bundles and states of the charger fault sequencer.
// Assumes one 25 MHz clock shared with the AHB-Lite register bus.
package cfs_pkg;
  localparam int unsigned CLK_HZ     = 25_000_000;
  // Recharge deglitch in milliseconds and in clock cycles.
  localparam int unsigned DGL_MS     = 25;
  localparam int unsigned DGL_CYC    = (DGL_MS * CLK_HZ) / 1000;
  // Length of each battery-absent detect phase.
  localparam int unsigned DET_MS     = 10;
  localparam int unsigned DET_CYC    = (DET_MS * CLK_HZ) / 1000;
  // Default fast-charge timeout in cycles, software may rewrite it.
  localparam logic [31:0] SAFE_RST   = 32'h0100_0000;
  // Register byte offsets.
  localparam logic [7:0]  REG_TIMEOUT = 8'h00;
  localparam logic [7:0]  REG_STATUS  = 8'h04;
  localparam logic [7:0]  REG_TIMER   = 8'h08;
  localparam logic [31:0] CNT_RST     = 32'h0000_0000;

  // Comparator and control levels arriving from the analog side and pins.
  typedef struct packed {
    logic chg_en;
    logic in_power;
    logic in_overvolt;
    logic temp_fault;
    logic timer_pin_open;
    logic term_det;
    logic vreg_reached;
    logic above_rch;
    logic below_lowv;
    logic below_scind;
    logic below_sc;
    logic stat_a_in;
    logic stat_b_in;
  } cfs_pins_s;

  // Enables for the power stage and the small current sources.
  typedef struct packed {
    logic pwr_en;
    logic fast_cur;
    logic pre_cur;
    logic dis_det_cur;
    logic chg_det_cur;
    logic fault_cur;
    logic short_cur;
  } cfs_drive_s;

  typedef enum logic [2:0] {
    ST_STANDBY,
    ST_CHARGE,
    ST_DONE,
    ST_DGL,
    ST_DET_DN,
    ST_DET_UP
  } cfs_state_e;
endpackage

// [hw/cfs_charger_fault_sequencer.sv]
// Charger control sequencer: absent test, safety timer, short handling.
// Assumes asynchronous analog comparator levels on pins_i and a single
// AHB-Lite master; status pins are open drain resolved outside.
// What this block does
// - After termination, no absent test while sense voltage stays above recharge.
// - At recharge threshold, discharge current one interval, then check below precharge.
// - Then charge current one interval, then check above recharge threshold.
// - Both phases pass: report battery absent fault on both status outputs.
// - Either phase fails: start a new charge cycle instead.
// - Termination disabled keeps done from starting absent detection; deglitch and detect phases ignore it.
// - Floating timer pin selects no-termination mode.
// - Recharge deglitch about 25 ms; below precharge meanwhile is a fault.
// - Safety timer starts with the fast-charge phase.
// - Floating timer pin disables safety timer, held in reset.
// - Count only charging above precharge; reset in standby or below precharge.
// - Suspend above precharge holds the count without clearing.
// - Temperature fault clearing resumes counting from the held value.
// - Timer expiry sets fault latch, shows fault, turns charger off.
// - Latched fault drives recovery current with power present below recharge.
// - Latch cleared by enable rise, overvoltage, power loss or new cycle.
// - Sense below about 1.8 V: both status outputs high impedance.
// - Below about 1.4 V: power stage off, 22 mA recovery current on.
// - Between short and precharge thresholds: precharge current regulation.
// - Above precharge before voltage regulation: fast-charge current regulation.
// - Charge done: first status output released, second pulled low.
module cfs_charger_fault_sequencer #(
  parameter int unsigned DGL_CYCLES = cfs_pkg::DGL_CYC,
  parameter int unsigned DET_CYCLES = cfs_pkg::DET_CYC
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire cfs_pkg::cfs_pins_s pins_i,
  output cfs_pkg::cfs_drive_s    drive_o,
  output logic                   status_out_a,
  output logic                   status_oe_a_n,
  output logic                   status_out_b,
  output logic                   status_oe_b_n
);
  cfs_pkg::cfs_pins_s  sync1_r;
  cfs_pkg::cfs_pins_s  pin_r;
  cfs_pkg::cfs_state_e st_r;
  cfs_pkg::cfs_state_e st_nxt;
  cfs_pkg::cfs_drive_s drive_nxt;
  logic [31:0] timeout_r;
  logic [31:0] safe_cnt_r;
  logic [31:0] safe_cnt_nxt;
  logic [31:0] dgl_cnt_r;
  logic [31:0] det_cnt_r;
  logic [31:0] hrdata_nxt;
  logic [7:0]  addr_r;
  logic        wr_r;
  logic        ce_d_r;
  logic        tfault_r;
  logic        absent_r;
  logic        oe_a_n_nxt;
  logic        oe_b_n_nxt;

  // Inputs come from comparators and pins: two flops before any use.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= '0;
      pin_r   <= '0;
    end else begin
      sync1_r <= pins_i;
      pin_r   <= sync1_r;
    end
  end

  wire run_ok    = pin_r.chg_en && pin_r.in_power && !pin_r.in_overvolt;
  wire ce_rise   = pin_r.chg_en && !ce_d_r;
  wire term_en   = !pin_r.timer_pin_open;
  wire suspend   = pin_r.temp_fault;
  wire in_charge = (st_r == cfs_pkg::ST_CHARGE);
  wire det_end   = (det_cnt_r == DET_CYCLES - 1);
  wire dgl_end   = (dgl_cnt_r == DGL_CYCLES - 1);
  wire safe_run  = in_charge && term_en && !pin_r.below_lowv && !suspend;
  wire expire    = safe_run && (safe_cnt_r >= timeout_r);
  wire dgl_fault = (st_r == cfs_pkg::ST_DGL) && pin_r.below_lowv;
  wire new_cycle = (st_nxt == cfs_pkg::ST_CHARGE) && !in_charge;

  // Charge sequence and absent test.
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      cfs_pkg::ST_STANDBY: begin
        if (run_ok && !tfault_r) begin
          st_nxt = cfs_pkg::ST_CHARGE;
        end
      end
      cfs_pkg::ST_CHARGE: begin
        if (expire) begin
          st_nxt = cfs_pkg::ST_STANDBY;
        end else if (pin_r.term_det && term_en && !suspend) begin
          st_nxt = cfs_pkg::ST_DONE;
        end
      end
      cfs_pkg::ST_DONE: begin
        if (!term_en) begin
          st_nxt = cfs_pkg::ST_CHARGE;
        end else if (!pin_r.above_rch) begin
          st_nxt = cfs_pkg::ST_DGL;
        end
      end
      cfs_pkg::ST_DGL: begin
        if (dgl_fault) begin
          st_nxt = cfs_pkg::ST_STANDBY;
        end else if (pin_r.above_rch) begin
          st_nxt = cfs_pkg::ST_DONE;
        end else if (dgl_end) begin
          st_nxt = cfs_pkg::ST_DET_DN;
        end
      end
      cfs_pkg::ST_DET_DN: begin
        if (det_end) begin
          st_nxt = pin_r.below_lowv ? cfs_pkg::ST_DET_UP : cfs_pkg::ST_CHARGE;
        end
      end
      cfs_pkg::ST_DET_UP: begin
        if (det_end) begin
          st_nxt = pin_r.above_rch ? cfs_pkg::ST_DONE : cfs_pkg::ST_CHARGE;
        end
      end
    endcase
    if (!run_ok) begin
      st_nxt = cfs_pkg::ST_STANDBY;
    end
  end

  always_comb begin
    if (!in_charge || !term_en || pin_r.below_lowv) begin
      safe_cnt_nxt = cfs_pkg::CNT_RST;
    end else if (suspend) begin
      safe_cnt_nxt = safe_cnt_r;
    end else begin
      safe_cnt_nxt = safe_cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r       <= cfs_pkg::ST_STANDBY;
      safe_cnt_r <= cfs_pkg::CNT_RST;
      ce_d_r     <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      safe_cnt_r <= safe_cnt_nxt;
      ce_d_r     <= pin_r.chg_en;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      det_cnt_r <= cfs_pkg::CNT_RST;
      dgl_cnt_r <= cfs_pkg::CNT_RST;
    end else begin
      det_cnt_r <= (st_nxt != st_r || det_end) ? cfs_pkg::CNT_RST : det_cnt_r + 32'h0000_0001;
      dgl_cnt_r <= (st_r != cfs_pkg::ST_DGL) ? cfs_pkg::CNT_RST : dgl_cnt_r + 32'h0000_0001;
    end
  end

  // Fault latches; a setting event wins over a clearing one.
  // expiry latches fault
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tfault_r <= 1'b0;
      absent_r <= 1'b0;
    end else begin
      if (expire || dgl_fault) begin
        tfault_r <= 1'b1;
      end else if (ce_rise || pin_r.in_overvolt || !pin_r.in_power || new_cycle) begin
        tfault_r <= 1'b0;
      end
      if (st_r == cfs_pkg::ST_DET_UP && det_end && pin_r.above_rch) begin
        absent_r <= 1'b1;
      end else if (new_cycle || !run_ok) begin
        absent_r <= 1'b0;
      end
    end
  end

  // Power stage and current source selection.
  wire pwr_on = in_charge && !suspend && !pin_r.below_sc && !expire;
  always_comb begin
    drive_nxt             = '0;
    drive_nxt.pwr_en      = pwr_on;
    drive_nxt.short_cur   = in_charge && pin_r.below_sc;
    drive_nxt.pre_cur     = pwr_on && pin_r.below_lowv;
    drive_nxt.fast_cur    = pwr_on && !pin_r.below_lowv && !pin_r.vreg_reached;
    drive_nxt.dis_det_cur = (st_nxt == cfs_pkg::ST_DET_DN);
    drive_nxt.chg_det_cur = (st_nxt == cfs_pkg::ST_DET_UP);
    drive_nxt.fault_cur   = tfault_r && pin_r.in_power && !pin_r.above_rch;
  end

  // Status pins: low enable means the pin is pulled low.
  // short indication
  always_comb begin
    oe_a_n_nxt = 1'b1;
    oe_b_n_nxt = 1'b1;
    if (pin_r.below_scind || tfault_r || absent_r || st_r == cfs_pkg::ST_STANDBY) begin
      oe_a_n_nxt = 1'b1;
      oe_b_n_nxt = 1'b1;
    end else if (in_charge) begin
      oe_a_n_nxt = 1'b0;
    end else begin
      oe_b_n_nxt = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_o       <= '0;
      status_oe_a_n <= 1'b1;
      status_oe_b_n <= 1'b1;
    end else begin
      drive_o       <= drive_nxt;
      status_oe_a_n <= oe_a_n_nxt;
      status_oe_b_n <= oe_b_n_nxt;
    end
  end

  assign status_out_a = 1'b0;
  assign status_out_b = 1'b0;

  // AHB-Lite slave: zero wait states, always OKAY, read data latched
  // at the address phase so it stands through the data phase.
  wire addr_ok = hsel && htrans[1] && hready;
  wire [7:0] a = haddr[7:0];
  wire [31:0] status_word = {17'h0_0000, pin_r.stat_a_in, pin_r.stat_b_in, pin_r.below_sc,
                             pin_r.below_scind, pin_r.below_lowv, pin_r.above_rch,
                             pin_r.timer_pin_open, tfault_r, absent_r, 3'h0, st_r};
  assign hrdata_nxt = (a == cfs_pkg::REG_TIMEOUT) ? timeout_r :
                      (a == cfs_pkg::REG_STATUS)  ? status_word :
                      (a == cfs_pkg::REG_TIMER)   ? safe_cnt_r : 32'h0000_0000;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r      <= 1'b0;
      addr_r    <= 8'h00;
      hrdata    <= 32'h0000_0000;
      timeout_r <= cfs_pkg::SAFE_RST;
    end else begin
      wr_r   <= addr_ok && hwrite;
      addr_r <= a;
      if (addr_ok && !hwrite) begin
        hrdata <= hrdata_nxt;
      end
      if (wr_r && addr_r == cfs_pkg::REG_TIMEOUT) begin
        timeout_r <= hwdata;
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_done_idle;
    (st_r == cfs_pkg::ST_DONE) && pin_r.above_rch && run_ok && term_en |=> st_r == cfs_pkg::ST_DONE;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("absent test began above recharge");
  property p_det_entry;
    $rose(st_r == cfs_pkg::ST_DET_DN) |-> $past(st_r) == cfs_pkg::ST_DGL;
  endproperty
  a_det_entry: assert property (p_det_entry) else $error("discharge phase without deglitch");
  property p_det_up;
    (st_r == cfs_pkg::ST_DET_DN) && det_end && pin_r.below_lowv && run_ok
      |=> st_r == cfs_pkg::ST_DET_UP ##1 drive_o.chg_det_cur;
  endproperty
  a_det_up: assert property (p_det_up) else $error("charge phase not started");
  property p_absent_stat;
    absent_r |=> status_oe_a_n && status_oe_b_n;
  endproperty
  a_absent_stat: assert property (p_absent_stat) else $error("absent fault not shown");
  property p_fail_restart;
    (st_r == cfs_pkg::ST_DET_UP) && det_end && !pin_r.above_rch && run_ok |=> in_charge;
  endproperty
  a_fail_restart: assert property (p_fail_restart) else $error("failed test did not restart");
  property p_open_no_det;
    pin_r.timer_pin_open && $past(pin_r.timer_pin_open)
      |=> !drive_o.dis_det_cur && !drive_o.chg_det_cur;
  endproperty
  a_open_no_det: assert property (p_open_no_det) else $error("absent test with no termination");
  property p_open_reset;
    pin_r.timer_pin_open |=> safe_cnt_r == 32'h0000_0000;
  endproperty
  a_open_reset: assert property (p_open_reset) else $error("timer counting with pin open");
  property p_hold;
    in_charge && suspend && !pin_r.below_lowv && term_en |=> $stable(safe_cnt_r);
  endproperty
  a_hold: assert property (p_hold) else $error("timer not held in suspend");
  property p_expire;
    expire |=> tfault_r && !in_charge ##1 !drive_o.pwr_en;
  endproperty
  a_expire: assert property (p_expire) else $error("expiry did not latch fault");
  property p_ce_clear;
    ce_rise && !expire && !dgl_fault |=> !tfault_r;
  endproperty
  a_ce_clear: assert property (p_ce_clear) else $error("enable rise left fault latched");
  property p_short;
    in_charge && pin_r.below_sc |=> !drive_o.pwr_en && drive_o.short_cur;
  endproperty
  a_short: assert property (p_short) else $error("short did not stop power stage");

  c_absent:  cover property ($rose(absent_r));
  c_expire:  cover property (expire);
  c_restart: cover property ((st_r == cfs_pkg::ST_DET_DN) ##1 in_charge);
  c_fault_i: cover property (drive_o.fault_cur);
endmodule // cfs_charger_fault_sequencer

// [sim/cfs_battery_model.sv]
// Behavioural battery pack or empty output seen by the charger sequencer.
// Assumes the bench sets the resting voltage and whether a pack is fitted.
module cfs_battery_model #(
  parameter int unsigned RCH_MV   = 4100,
  parameter int unsigned LOWV_MV  = 3000,
  parameter int unsigned SCIND_MV = 1800,
  parameter int unsigned SC_MV    = 1400,
  parameter int unsigned DN_MV    = 2500,
  parameter int unsigned UP_MV    = 4150
) (
  input  wire logic                present,
  input  wire logic [12:0]         set_mv,
  input  wire cfs_pkg::cfs_drive_s drive,
  output logic                     above_rch,
  output logic                     below_lowv,
  output logic                     below_scind,
  output logic                     below_sc
);
  int unsigned v_mv;

  // A fitted pack holds its voltage; an empty output follows the test currents.
  always_comb begin
    v_mv = set_mv;
    if (!present && drive.dis_det_cur) begin
      v_mv = DN_MV;
    end
    if (!present && drive.chg_det_cur) begin
      v_mv = UP_MV;
    end
  end

  assign above_rch   = (v_mv > RCH_MV);
  assign below_lowv  = (v_mv < LOWV_MV);
  assign below_scind = (v_mv < SCIND_MV);
  assign below_sc    = (v_mv < SC_MV);
endmodule // cfs_battery_model

// [sim/testbench.sv]
// Self-checking bench: AHB-Lite register access and pin stimulus.
// Assumes the battery model at the output and pull-ups on status pins.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]         haddr, hwdata, hrdata, rd, t1;
  logic [1:0]          htrans;
  logic [2:0]          hsize;
  logic                chg_en, in_power, in_overvolt, temp_fault, timer_pin_open, term_det;
  logic                vreg;
  logic                present, a_out, a_oe_n, b_out, b_oe_n;
  logic                ab_rch, bl_lowv, bl_scind, bl_sc;
  logic [12:0]         set_mv;
  cfs_pkg::cfs_pins_s  pins;
  cfs_pkg::cfs_drive_s drv;
  int                  n_mismatch, samples_checked, i;

  assign pins = {chg_en, in_power, in_overvolt, temp_fault, timer_pin_open, term_det, vreg,
                 ab_rch, bl_lowv, bl_scind, bl_sc, (a_oe_n ? 1'b1 : a_out),
                 (b_oe_n ? 1'b1 : b_out)};

  cfs_charger_fault_sequencer #(.DGL_CYCLES(20), .DET_CYCLES(16)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins_i(pins),
    .drive_o(drv), .status_out_a(a_out), .status_oe_a_n(a_oe_n),
    .status_out_b(b_out), .status_oe_b_n(b_oe_n));

  cfs_battery_model batt (
    .present(present), .set_mv(set_mv), .drive(drv), .above_rch(ab_rch),
    .below_lowv(bl_lowv), .below_scind(bl_scind), .below_sc(bl_sc));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // One single word transfer; read data lands in rd.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'b10;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wait_reg(input logic [31:0] m, input logic [31:0] v);
    int k;
    for (k = 0; k < 100; k++) begin
      xfer(1'b0, cfs_pkg::REG_STATUS, 32'h0);
      if ((rd & m) === v) break;
    end
    chk(rd & m, v);
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  initial begin
    #(40 * 20000);
    n_mismatch++;
    finish_test();
  end

  initial begin
    {hresetn, hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
    {chg_en, in_power, in_overvolt, temp_fault, timer_pin_open, term_det, vreg} = '0;
    present = 1'b1;
    set_mv = 13'd3500;
    cyc(10);
    hresetn <= 1'b1;
    xfer(1'b0, cfs_pkg::REG_TIMEOUT, 32'h0);
    chk(rd, cfs_pkg::SAFE_RST);
    chk({hresp, hreadyout, a_out, b_out}, 4'b0100);
    xfer(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b1, cfs_pkg::REG_TIMER, 32'h5a5a);
    xfer(1'b0, cfs_pkg::REG_TIMER, 32'h0);
    chk(rd, cfs_pkg::CNT_RST);
    @(posedge hclk);
    chg_en <= 1'b1;
    in_power <= 1'b1;
    wait_reg(32'h7, 32'h1);
    cyc(3);
    #1;
    chk({drv.pwr_en, drv.fast_cur, a_oe_n, b_oe_n}, 4'b1101);
    @(posedge hclk);
    vreg <= 1'b1;
    cyc(4);
    #1;
    chk(drv.fast_cur, 1'b0);
    @(posedge hclk);
    vreg <= 1'b0;
    xfer(1'b0, cfs_pkg::REG_TIMER, 32'h0);
    t1 = rd;
    xfer(1'b0, cfs_pkg::REG_TIMER, 32'h0);
    chk(rd > t1, 1);
    @(posedge hclk);
    temp_fault <= 1'b1;
    cyc(6);
    xfer(1'b0, cfs_pkg::REG_TIMER, 32'h0);
    t1 = rd;
    cyc(10);
    xfer(1'b0, cfs_pkg::REG_TIMER, 32'h0);
    chk(rd, t1);
    temp_fault <= 1'b0;
    cyc(6);
    xfer(1'b0, cfs_pkg::REG_TIMER, 32'h0);
    chk(rd > t1, 1);
    set_mv <= 13'd2500;
    cyc(6);
    xfer(1'b0, cfs_pkg::REG_TIMER, 32'h0);
    chk(rd, 32'h0);
    #1;
    chk({drv.fast_cur, drv.pre_cur}, 2'b01);
    @(posedge hclk);
    set_mv <= 13'd1600;
    cyc(6);
    #1;
    chk({a_oe_n, b_oe_n}, 2'b11);
    @(posedge hclk);
    set_mv <= 13'd1200;
    cyc(6);
    #1;
    chk({drv.pwr_en, drv.short_cur}, 2'b01);
    @(posedge hclk);
    set_mv <= 13'd3500;
    timer_pin_open <= 1'b1;
    term_det <= 1'b1;
    cyc(8);
    xfer(1'b0, cfs_pkg::REG_TIMER, 32'h0);
    chk(rd, 32'h0);
    wait_reg(32'h7, 32'h1);
    timer_pin_open <= 1'b0;
    term_det <= 1'b0;
    xfer(1'b1, cfs_pkg::REG_TIMEOUT, 32'd50);
    wait_reg(32'h87, 32'h80);
    #1;
    chk({drv.pwr_en, drv.fault_cur, a_oe_n, b_oe_n}, 4'b0111);
    for (i = 0; i < 3; i++) begin
      @(posedge hclk);
      chg_en <= (i != 0);
      in_overvolt <= (i == 1);
      in_power <= (i != 2);
      cyc(6);
      chg_en <= 1'b1;
      in_overvolt <= 1'b0;
      in_power <= 1'b1;
      cyc(3);
      xfer(1'b0, cfs_pkg::REG_STATUS, 32'h0);
      chk(rd[7], 1'b0);
      wait_reg(32'h80, 32'h80);
    end
    xfer(1'b1, cfs_pkg::REG_TIMEOUT, 32'h00ff_ffff);
    chg_en <= 1'b0;
    cyc(6);
    chg_en <= 1'b1;
    set_mv <= 13'd4150;
    term_det <= 1'b1;
    wait_reg(32'h7, 32'h2);
    #1;
    chk({a_oe_n, b_oe_n}, 2'b10);
    @(posedge hclk);
    term_det <= 1'b0;
    cyc(30);
    xfer(1'b0, cfs_pkg::REG_STATUS, 32'h0);
    chk({rd[2:0], drv.dis_det_cur}, 4'b0100);
    set_mv <= 13'd3900;
    wait_reg(32'h7, 32'h1);
    set_mv <= 13'd4150;
    term_det <= 1'b1;
    wait_reg(32'h7, 32'h2);
    term_det <= 1'b0;
    present <= 1'b0;
    set_mv <= 13'd3900;
    wait_reg(32'h7, 32'h4);
    #1;
    chk(drv.dis_det_cur, 1'b1);
    wait_reg(32'h7, 32'h5);
    #1;
    chk(drv.chg_det_cur, 1'b1);
    wait_reg(32'h40, 32'h40);
    #1;
    chk({a_oe_n, b_oe_n}, 2'b11);
    @(posedge hclk);
    present <= 1'b1;
    set_mv <= 13'd4150;
    term_det <= 1'b1;
    wait_reg(32'h7, 32'h2);
    term_det <= 1'b0;
    set_mv <= 13'd2500;
    wait_reg(32'h80, 32'h80);
    finish_test();
  end
endmodule // testbench
